// [src/bof_bit_alu.sv]
// Bit modify unit: clears, sets or tests one bit of a data byte
`timescale 1ns/1ps
`default_nettype none

module bof_bit_alu (
	// Operand
	input  wire logic [bof_pkg::DATA_W-1:0] data,
	input  wire logic [bof_pkg::BIT_W-1:0]  bitnum,
	input  wire bof_pkg::bof_op_t           op,
	// Result
	output logic      [bof_pkg::DATA_W-1:0] result,
	output logic                            bit_val
);

	function automatic logic [bof_pkg::DATA_W-1:0] bit_mask(
		input logic [bof_pkg::BIT_W-1:0] b);
		bit_mask = bof_pkg::BIT0_MASK << b;
	endfunction

	always_comb begin
		bit_val = |(data & bit_mask(bitnum));
		case (op)
			bof_pkg::BOF_OP_CLEAR: result = data & ~bit_mask(bitnum);
			bof_pkg::BOF_OP_SET:   result = data | bit_mask(bitnum);
			default:               result = data;
		endcase
	end

endmodule

`default_nettype wire

// [src/bof_bit_file_ops.sv]
// Four-phase decode and execute of the clear, set and test-skip bit instructions
// Summary of operation
// - Instruction carries a 7-bit file address and 3-bit bit number.
// - Clear-bit op writes zero to selected bit, others unchanged.
// - Set-bit op writes one to selected bit in one cycle.
// - Test-skip op with bit zero discards next instruction, runs a NOP.
// - Test-skip op with bit one completes in one cycle, no skip.
`timescale 1ns/1ps
`default_nettype none

module bof_bit_file_ops (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// Fetched instruction, stable during Q1
	input  wire logic [bof_pkg::INSTR_W-1:0]    instr,
	// File register read data
	input  wire logic [bof_pkg::DATA_W-1:0]     fr_rdata,
	// File register access
	output logic      [bof_pkg::ADDR_W-1:0]     fr_addr,
	output logic                                fr_rd,
	output logic                                fr_wr,
	output logic      [bof_pkg::DATA_W-1:0]     fr_wdata,
	// Core status
	output bof_pkg::bof_phase_t                 phase,
	output logic                                skip_active,
	output logic                                status_we
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       rst_int_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_int_n = rst_sync[1];

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic bof_pkg::bof_dec_t decode(input logic [bof_pkg::INSTR_W-1:0] w);
		bof_pkg::bof_dec_t d;
		d.bitnum = w[bof_pkg::BIT_HI:bof_pkg::BIT_LO];
		d.addr   = w[bof_pkg::ADDR_HI:bof_pkg::ADDR_LO];
		case (w[bof_pkg::OPC_HI:bof_pkg::OPC_LO])
			bof_pkg::OPC_CLEAR: d.op = bof_pkg::BOF_OP_CLEAR;
			bof_pkg::OPC_SET:   d.op = bof_pkg::BOF_OP_SET;
			bof_pkg::OPC_TEST:  d.op = bof_pkg::BOF_OP_TEST;
			default:            d.op = bof_pkg::BOF_OP_NONE;
		endcase
		return d;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bof_pkg::bof_phase_t           state;
	bof_pkg::bof_phase_t           next_state;
	bof_pkg::bof_dec_t             dec;
	bof_pkg::bof_dec_t             next_dec;
	logic [bof_pkg::DATA_W-1:0]    rdata;
	logic [bof_pkg::DATA_W-1:0]    next_rdata;
	logic                          skip_pend;
	logic                          next_skip_pend;
	logic                          nop_cycle;
	logic                          next_nop_cycle;
	logic [bof_pkg::ADDR_W-1:0]    next_fr_addr;
	logic                          next_fr_rd;
	logic                          next_fr_wr;
	logic [bof_pkg::DATA_W-1:0]    next_fr_wdata;
	logic [bof_pkg::DATA_W-1:0]    alu_result;
	logic                          alu_bit;

	bof_bit_alu u_alu (
		.data    (rdata),
		.bitnum  (dec.bitnum),
		.op      (dec.op),
		.result  (alu_result),
		.bit_val (alu_bit)
	);

	always_comb begin
		next_state     = state;
		next_dec       = dec;
		next_rdata     = rdata;
		next_skip_pend = skip_pend;
		next_nop_cycle = nop_cycle;
		next_fr_addr   = fr_addr;
		next_fr_rd     = 1'b0;
		next_fr_wr     = 1'b0;
		next_fr_wdata  = fr_wdata;
		case (state)
			bof_pkg::BOF_Q1: begin
				next_state = bof_pkg::BOF_Q2;
				if (nop_cycle) begin
					next_dec = bof_pkg::DEC_RST;
				end else begin
					next_dec = decode(instr);
				end
				next_fr_addr = next_dec.addr;
				next_fr_rd   = (next_dec.op != bof_pkg::BOF_OP_NONE);
			end
			bof_pkg::BOF_Q2: begin
				next_state = bof_pkg::BOF_Q3;
				next_rdata = fr_rdata;
			end
			bof_pkg::BOF_Q3: begin
				next_state = bof_pkg::BOF_Q4;
				// modify in Q3, write lands in Q4
				next_fr_wr    = (dec.op == bof_pkg::BOF_OP_CLEAR) ||
				                (dec.op == bof_pkg::BOF_OP_SET);
				next_fr_wdata = alu_result;
				// skip only on a clear bit
				next_skip_pend = (dec.op == bof_pkg::BOF_OP_TEST) && !alu_bit;
			end
			bof_pkg::BOF_Q4: begin
				next_state     = bof_pkg::BOF_Q1;
				next_nop_cycle = skip_pend;
				next_skip_pend = 1'b0;
			end
			default: begin
				next_state = bof_pkg::BOF_Q1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			state     <= bof_pkg::BOF_Q1;
			dec       <= bof_pkg::DEC_RST;
			rdata     <= bof_pkg::DATA_RST;
			skip_pend <= 1'b0;
			nop_cycle <= 1'b0;
			fr_addr   <= bof_pkg::ADDR_RST;
			fr_rd     <= 1'b0;
			fr_wr     <= 1'b0;
			fr_wdata  <= bof_pkg::DATA_RST;
			phase     <= bof_pkg::BOF_Q1;
			skip_active <= 1'b0;
			status_we <= 1'b0;
		end else begin
			state     <= next_state;
			dec       <= next_dec;
			rdata     <= next_rdata;
			skip_pend <= next_skip_pend;
			nop_cycle <= next_nop_cycle;
			fr_addr   <= next_fr_addr;
			fr_rd     <= next_fr_rd;
			fr_wr     <= next_fr_wr;
			fr_wdata  <= next_fr_wdata;
			phase     <= next_state;
			skip_active <= next_nop_cycle;
			// bit ops never touch status flags
			status_we <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_int_n);

	logic [bof_pkg::DATA_W-1:0] chk_mask;
	assign chk_mask = bof_pkg::BIT0_MASK << dec.bitnum;

	sequence seq_phase_walk;
		state == bof_pkg::BOF_Q2 ##1 state == bof_pkg::BOF_Q3 ##1 state == bof_pkg::BOF_Q4;
	endsequence

	sequence seq_nop_cycle;
		skip_active [*4];
	endsequence

	a_phase_walk: assert property (
		state == bof_pkg::BOF_Q1 |=> seq_phase_walk ##1 state == bof_pkg::BOF_Q1)
		else $error("phase order broken");

	a_write_in_q4: assert property (
		fr_wr |-> state == bof_pkg::BOF_Q4 && !status_we)
		else $error("write outside Q4 or status touched");

	a_read_address: assert property (
		fr_rd |-> state == bof_pkg::BOF_Q2 && fr_addr == dec.addr)
		else $error("read address does not match decoded field");

	a_clear_bit: assert property (
		state == bof_pkg::BOF_Q3 && dec.op == bof_pkg::BOF_OP_CLEAR
		|=> fr_wr && (fr_wdata & chk_mask) == bof_pkg::DATA_RST
		    && (fr_wdata | chk_mask) == (rdata | chk_mask))
		else $error("clear wrote wrong value");

	a_set_bit: assert property (
		state == bof_pkg::BOF_Q3 && dec.op == bof_pkg::BOF_OP_SET
		|=> fr_wr && fr_wdata == (rdata | chk_mask))
		else $error("set wrote wrong value");

	a_skip_on_zero: assert property (
		state == bof_pkg::BOF_Q3 && dec.op == bof_pkg::BOF_OP_TEST && !rdata[dec.bitnum]
		|=> !fr_wr ##1 seq_nop_cycle ##1 !skip_active)
		else $error("skip cycle missing or wrong length");

	a_nop_discards: assert property (
		skip_active && state == bof_pkg::BOF_Q1 |=> dec.op == bof_pkg::BOF_OP_NONE && !fr_rd)
		else $error("skipped instruction was executed");

	a_no_skip_on_one: assert property (
		state == bof_pkg::BOF_Q3 && dec.op == bof_pkg::BOF_OP_TEST && rdata[dec.bitnum]
		|=> !fr_wr ##1 !skip_active [*4])
		else $error("skip taken on a set bit");

endmodule

`default_nettype wire

// [src/bof_pkg.sv]
// Constants and types for the bit-oriented file register operations
package bof_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int ADDR_W  = 7;
	localparam int BIT_W   = 3;
	localparam int DATA_W  = 8;
	localparam int OPC_W   = 4;

	// ------------------------------------------------------------
	// Instruction field positions
	// ------------------------------------------------------------
	localparam int OPC_HI  = 13;
	localparam int OPC_LO  = 10;
	localparam int BIT_HI  = 9;
	localparam int BIT_LO  = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;

	// ------------------------------------------------------------
	// Upper four bits of each bit instruction
	// ------------------------------------------------------------
	localparam logic [OPC_W-1:0] OPC_CLEAR = 4'h4;
	localparam logic [OPC_W-1:0] OPC_SET   = 4'h5;
	localparam logic [OPC_W-1:0] OPC_TEST  = 4'h6;

	// ------------------------------------------------------------
	// Reset values and bit-zero mask
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [BIT_W-1:0]  BIT_RST  = 3'h0;
	localparam logic [DATA_W-1:0] BIT0_MASK = 8'h01;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BOF_OP_NONE  = 2'h0,
		BOF_OP_CLEAR = 2'h1,
		BOF_OP_SET   = 2'h2,
		BOF_OP_TEST  = 2'h3
	} bof_op_t;

	typedef enum logic [3:0] {
		BOF_Q1 = 4'b0001,
		BOF_Q2 = 4'b0010,
		BOF_Q3 = 4'b0100,
		BOF_Q4 = 4'b1000
	} bof_phase_t;

	typedef struct packed {
		bof_op_t           op;
		logic [BIT_W-1:0]  bitnum;
		logic [ADDR_W-1:0] addr;
	} bof_dec_t;

	localparam bof_dec_t DEC_RST = '{op: BOF_OP_NONE, bitnum: BIT_RST, addr: ADDR_RST};

endpackage

// [testbench/testbench.sv]
// Self-checking bench for the bit clear, set and test-skip operations
`timescale 1ns/1ps
`default_nettype none

module testbench;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                           clk;
	logic                           rst_n;
	logic [bof_pkg::INSTR_W-1:0]    instr;
	logic [bof_pkg::DATA_W-1:0]     fr_rdata;
	logic [bof_pkg::ADDR_W-1:0]     fr_addr;
	logic                           fr_rd;
	logic                           fr_wr;
	logic [bof_pkg::DATA_W-1:0]     fr_wdata;
	bof_pkg::bof_phase_t            phase;
	logic                           skip_active;
	logic                           status_we;
	int                             err_count;
	int                             cmp_count;

	bof_bit_file_ops DUT (
		.clk         (clk),
		.rst_n       (rst_n),
		.instr       (instr),
		.fr_rdata    (fr_rdata),
		.fr_addr     (fr_addr),
		.fr_rd       (fr_rd),
		.fr_wr       (fr_wr),
		.fr_wdata    (fr_wdata),
		.phase       (phase),
		.skip_active (skip_active),
		.status_we   (status_we)
	);

	always #20 clk = ~clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One instruction cycle, Q1 through Q4, judged phase by phase
	task automatic do_op(input logic [3:0] op, input logic [2:0] b, input logic [6:0] f,
			input logic [7:0] rdata, input logic exp_rd, input logic exp_wr,
			input logic [7:0] exp_wdata, input logic skip_now);
		int n;
		n = 0;
		@(negedge clk);
		while (phase !== bof_pkg::BOF_Q1) begin
			@(negedge clk);
			n++;
			if (n > 8) begin
				err_count++;
				stop_test();
			end
		end
		instr = {op, b, f};
		fr_rdata = rdata;
		chk(skip_active, skip_now);
		@(negedge clk);
		chk(phase, bof_pkg::BOF_Q2);
		chk(fr_rd, exp_rd);
		if (exp_rd) chk(fr_addr, f);
		@(negedge clk);
		chk(phase, bof_pkg::BOF_Q3);
		chk({fr_rd, fr_wr}, 2'b00);
		instr = ~instr;
		fr_rdata = ~rdata;
		@(negedge clk);
		chk(phase, bof_pkg::BOF_Q4);
		chk(fr_wr, exp_wr);
		if (exp_wr) chk(fr_wdata, exp_wdata);
		chk(status_we, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_clear();
		for (int b = 0; b < 8; b++) begin
			// Every bit number, address walking down from the top
			do_op(bof_pkg::OPC_CLEAR, b[2:0], 7'h7F - b[6:0], 8'hFF, 1'b1, 1'b1,
				8'hFF & ~(8'h01 << b), 1'b0);
		end
		do_op(bof_pkg::OPC_CLEAR, 3'h7, 7'h0C, 8'hC7, 1'b1, 1'b1, 8'h47, 1'b0);
	endtask

	task automatic t_set();
		for (int b = 0; b < 8; b++) begin
			do_op(bof_pkg::OPC_SET, b[2:0], b[6:0], 8'h00, 1'b1, 1'b1,
				8'h01 << b, 1'b0);
		end
		do_op(bof_pkg::OPC_SET, 3'h7, 7'h00, 8'h0A, 1'b1, 1'b1, 8'h8A, 1'b0);
	endtask

	task automatic t_skip();
		do_op(bof_pkg::OPC_TEST, 3'h3, 7'h20, 8'hF7, 1'b1, 1'b0, 8'h00, 1'b0);
		// Fetched word must be dropped: no access at all
		do_op(bof_pkg::OPC_SET, 3'h0, 7'h21, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
		do_op(bof_pkg::OPC_SET, 3'h0, 7'h21, 8'h00, 1'b1, 1'b1, 8'h01, 1'b0);
	endtask

	task automatic t_noskip();
		do_op(bof_pkg::OPC_TEST, 3'h3, 7'h22, 8'h08, 1'b1, 1'b0, 8'h00, 1'b0);
		do_op(bof_pkg::OPC_CLEAR, 3'h3, 7'h22, 8'h08, 1'b1, 1'b1, 8'h00, 1'b0);
		do_op(bof_pkg::OPC_TEST, 3'h0, 7'h7F, 8'hFF, 1'b1, 1'b0, 8'h00, 1'b0);
		do_op(bof_pkg::OPC_SET, 3'h7, 7'h7F, 8'h00, 1'b1, 1'b1, 8'h80, 1'b0);
	endtask

	task automatic t_other();
		// Opcodes 4'h7 and 4'h0, outside the bit opcodes, belong to other instruction classes
		do_op(4'h7, 3'h1, 7'h10, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
		do_op(4'h0, 3'h1, 7'h10, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
		do_op(bof_pkg::OPC_SET, 3'h1, 7'h10, 8'h00, 1'b1, 1'b1, 8'h02, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		instr = '0;
		fr_rdata = 8'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (4) @(negedge clk);
		chk({phase, fr_rd, fr_wr, skip_active, status_we}, {bof_pkg::BOF_Q1, 4'h0});
		rst_n = 1'b1;
		// Internal reset lifts two edges later; phase sits in Q1 until then
		repeat (2) @(negedge clk);
		t_clear();
		t_set();
		t_skip();
		t_noskip();
		t_other();
		stop_test();
	end

	initial begin
		#(40 * 2000);
		err_count++;
		stop_test();
	end

endmodule

`default_nettype wire
